// file: lcbr_link_capture_base_regs.sv
/*
 base register bank, port window decode, capture start control and link
 forwarding of a four-port link capture board.
 assumes per-port logic on ref_clk answers portRdData in the cycle its
 portRdEn is high, and capture pins arrive asynchronously.
*/
`timescale 1ns/100ps
`include "lcbr_cfg.svh"
module lcbr_link_capture_base_regs #(
    parameter logic [3:0] REV_MINOR = 4'h1, // arbitrary value
    parameter logic [3:0] CFG_TYPE = 4'h2, // arbitrary value
    parameter logic [7:0] REV_MAJOR = 8'h03 // arbitrary value
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [8:0] regAddr,
    input wire logic [31:0] regWrData,
    output logic [31:0] regRdData,
    output logic regRdValid,
    output logic [3:0] portWrEn,
    output logic [3:0] portRdEn,
    output logic [6:0] portOffset,
    output logic [31:0] portWrData,
    input wire logic [127:0] portRdData,
    output logic capPortRst,
    input wire logic [3:0] portIrq,
    input wire logic calDone,
    input wire logic [7:0] userSwitch,
    output logic synthFifoWr,
    output logic synthFifoRd,
    input wire logic [31:0] synthFifoRdData,
    input wire logic synthReady,
    input wire logic [2:0] synthRxFlags,
    input wire logic [2:0] synthTxFlags,
    input wire logic synthError,
    input wire logic synthDone,
    output logic [6:0] synthAddr,
    output logic synthProbe,
    output logic synthRead,
    output logic synthCtrlRst,
    output logic synthDriveEn,
    output logic memCtrlRst,
    output logic [31:0] timeCtl,
    output logic [31:0] timeRate,
    input wire logic [5:0] timeCount,
    output logic [7:0] timeCodeOut,
    input wire logic [31:0] dmaTxIn,
    output logic [31:0] dmaTxOut,
    input wire logic [31:0] dmaRxIn,
    output logic [31:0] dmaRxOut,
    output logic [19:0] linkDivisor,
    output logic [3:0] linkBitEn,
    input wire logic [1:0] capDataIn,
    input wire logic [1:0] capStrobeIn,
    output logic [1:0] capDataOut,
    output logic [1:0] capStrobeOut,
    output logic [1:0] capRxData,
    output logic [1:0] capRxStrobe,
    input wire logic selfTestLoop,
    output logic [3:0] txEnable,
    input wire logic [1:0] captureArm,
    input wire logic [1:0] captureUpStart,
    input wire logic [1:0] linkUp,
    input wire logic [1:0] eopSeen,
    input wire logic [1:0] dataAvail,
    output logic [1:0] captureEn,
    output logic [1:0] captureIrq
);
    lcbr_pkg::lcbr_state_t s, n;

    function automatic logic [31:0] byteReverse(input logic [31:0] w);
        byteReverse = {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction

    // window index 0..3, 4 when outside every port window
    function automatic logic [2:0] winIdx(input logic [8:0] a);
        logic [8:0] lo;
        winIdx = 3'd4;
        for (int i = 0; i < 4; i++)
        begin
            lo = 9'(`LCBR_PORT0_BASE + 9'(i) * `LCBR_PORT_WIN);
            if (a >= lo && a < 9'(lo + `LCBR_PORT_WIN))
            begin
                winIdx = 3'(i);
            end
        end
    endfunction

    function automatic logic [6:0] winOfs(input logic [8:0] a, input logic [2:0] i);
        winOfs = 7'(a - 9'(`LCBR_PORT0_BASE + 9'(i) * `LCBR_PORT_WIN));
    endfunction

    logic [2:0] wrIdx, rdIdx, pendIdx;
    assign wrIdx = winIdx(regAddr);
    assign pendIdx = winIdx(s.rdAddr);
    assign rdIdx = wrIdx;

    always_comb
    begin
        n = s;
        n.portRst = 1'b0;
        n.portWr = 4'h0;
        n.portRd = 4'h0;
        n.fifoWr = 1'b0;
        n.fifoRd = 1'b0;
        n.rdPend = regRdEn;
        n.rdAddr = regAddr;
        n.rdValid = s.rdPend;
        n.portWd = regWrData;
        n.portOff = (wrIdx == 3'd4) ? 7'h00 : winOfs(regAddr, wrIdx);
        if (regWrEn)
        begin
            case (regAddr)
                `LCBR_OFS_BASE_CTL: n.baseCtl = regWrData & `LCBR_BASE_CTL_WMASK;
                `LCBR_OFS_TIME_CTL: n.timeCtl = regWrData & `LCBR_TIME_CTL_WMASK;
                `LCBR_OFS_TIME_RATE: n.timeRate = regWrData;
                `LCBR_OFS_SYNTH_FIFO: n.fifoWr = 1'b1;
                default: n.fifoWr = 1'b0;
            endcase
            if (wrIdx != 3'd4)
            begin
                n.portWr[wrIdx[1:0]] = 1'b1;
            end
        end
        if (regRdEn)
        begin
            if (rdIdx != 3'd4)
            begin
                n.portRd[rdIdx[1:0]] = 1'b1;
            end
            n.fifoRd = (regAddr == `LCBR_OFS_SYNTH_FIFO);
        end
        // sticky flags, the set wins over a clear
        n.errLatch = synthError | (s.errLatch & ~(regWrEn
            && regAddr == `LCBR_OFS_SYNTH_STAT && regWrData[`LCBR_BIT_ERR]));
        n.doneLatch = synthDone | (s.doneLatch & ~(regWrEn
            && regAddr == `LCBR_OFS_SYNTH_STAT && regWrData[`LCBR_BIT_DONE]));
        n.rdData = 32'h0000_0000;
        if (s.rdPend)
        begin
            if (pendIdx != 3'd4)
            begin
                n.rdData = portRdData[32 * pendIdx[1:0] +: 32];
            end
            else
            begin
                case (s.rdAddr)
                    `LCBR_OFS_BASE_CTL: n.rdData = s.baseCtl;
                    `LCBR_OFS_SWITCH: n.rdData = {calDone, 3'h0, portIrq, REV_MINOR,
                        CFG_TYPE, REV_MAJOR, s.swSync};
                    `LCBR_OFS_TIME_CTL: n.rdData = s.timeCtl;
                    `LCBR_OFS_TIME_RATE: n.rdData = s.timeRate;
                    `LCBR_OFS_SYNTH_FIFO: n.rdData = synthFifoRdData;
                    `LCBR_OFS_SYNTH_STAT: n.rdData = {21'h0, s.errLatch, s.doneLatch,
                        synthReady, 1'b0, synthRxFlags, 1'b0, synthTxFlags};
                    default: n.rdData = 32'h0000_0000;
                endcase
            end
        end
        n.swMeta = userSwitch;
        n.swSync = s.swMeta;
        n.capMeta = {capStrobeIn, capDataIn};
        n.capSync = s.capMeta;
        // cross-forward to the opposite capture port
        n.fwdOut = {s.capSync[2], s.capSync[3], s.capSync[0], s.capSync[1]};
        // capture ports transmit only for loopback self test
        n.txEn = {2'b11, selfTestLoop, selfTestLoop};
        for (int p = 0; p < 2; p++)
        begin
            case (s.capState[p])
                lcbr_pkg::CAP_IDLE:
                begin
                    if (captureArm[p])
                    begin
                        n.capState[p] = captureUpStart[p] ? lcbr_pkg::CAP_WAIT_EOP
                            : lcbr_pkg::CAP_WAIT_LINK;
                    end
                end
                lcbr_pkg::CAP_WAIT_LINK:
                begin
                    if (!captureArm[p])
                        n.capState[p] = lcbr_pkg::CAP_IDLE;
                    else if (linkUp[p])
                        n.capState[p] = lcbr_pkg::CAP_RUN;
                end
                lcbr_pkg::CAP_WAIT_EOP:
                begin
                    if (!captureArm[p])
                        n.capState[p] = lcbr_pkg::CAP_IDLE;
                    else if (eopSeen[p] && linkUp[p])
                        n.capState[p] = lcbr_pkg::CAP_RUN;
                end
                lcbr_pkg::CAP_RUN:
                begin
                    if (!captureArm[p])
                        n.capState[p] = lcbr_pkg::CAP_IDLE;
                end
                default: n.capState[p] = lcbr_pkg::CAP_IDLE;
            endcase
            n.capEn[p] = (n.capState[p] == lcbr_pkg::CAP_RUN);
            n.capIrq[p] = dataAvail[p] & s.capEn[p];
        end
        n.dmaTx = s.baseCtl[`LCBR_BIT_SWAP] ? byteReverse(dmaTxIn) : dmaTxIn;
        n.dmaRx = s.baseCtl[`LCBR_BIT_SWAP] ? byteReverse(dmaRxIn) : dmaRxIn;
        // flag bits over the six-bit count
        n.timeCode = {s.baseCtl[`LCBR_BIT_TC_HI:`LCBR_BIT_TC_LO], timeCount};
        n.memRst = s.baseCtl[`LCBR_BIT_MEM_RST];
        n.synAddr = s.baseCtl[`LCBR_BIT_ALT_ADDR] ? `LCBR_SYNTH_ADDR_ALT : `LCBR_SYNTH_ADDR;
        n.synProbe = s.baseCtl[`LCBR_BIT_PROBE] & s.baseCtl[`LCBR_BIT_SYN_EN];
        n.synRead = s.baseCtl[`LCBR_BIT_READ] & s.baseCtl[`LCBR_BIT_SYN_EN];
        n.synRst = s.baseCtl[`LCBR_BIT_SYN_RST];
        n.synEn = s.baseCtl[`LCBR_BIT_SYN_EN];
        for (int c = 0; c < 4; c++)
        begin
            if (s.divCnt[5 * c +: 5] >= s.baseCtl[5 * c +: 5])
            begin
                n.divCnt[5 * c +: 5] = 5'h00;
                n.bitEn[c] = 1'b1;
            end
            else
            begin
                n.divCnt[5 * c +: 5] = 5'(s.divCnt[5 * c +: 5] + 5'h01);
                n.bitEn[c] = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
            s.baseCtl <= `LCBR_BASE_CTL_RST;
            s.portRst <= 1'b1;
            s.synEn <= 1'b1;
            s.synAddr <= `LCBR_SYNTH_ADDR;
        end
        else
        begin
            s <= n;
        end
    end

    assign regRdData = s.rdData;
    assign regRdValid = s.rdValid;
    assign portWrEn = s.portWr;
    assign portRdEn = s.portRd;
    assign portOffset = s.portOff;
    assign portWrData = s.portWd;
    assign capPortRst = s.portRst;
    assign synthFifoWr = s.fifoWr;
    assign synthFifoRd = s.fifoRd;
    assign synthAddr = s.synAddr;
    assign synthProbe = s.synProbe;
    assign synthRead = s.synRead;
    assign synthCtrlRst = s.synRst;
    assign synthDriveEn = s.synEn;
    assign memCtrlRst = s.memRst;
    assign timeCtl = s.timeCtl;
    assign timeRate = s.timeRate;
    assign timeCodeOut = s.timeCode;
    assign dmaTxOut = s.dmaTx;
    assign dmaRxOut = s.dmaRx;
    assign linkDivisor = s.baseCtl[19:0];
    assign linkBitEn = s.bitEn;
    assign capDataOut = s.fwdOut[1:0];
    assign capStrobeOut = s.fwdOut[3:2];
    assign capRxData = s.capSync[1:0];
    assign capRxStrobe = s.capSync[3:2];
    assign txEnable = s.txEn;
    assign captureEn = s.capEn;
    assign captureIrq = s.capIrq;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_base_reset_val:
        assert property (!$past(rst_n) |-> s.baseCtl == `LCBR_BASE_CTL_RST && synthDriveEn)
        else $error("base control reset value wrong");
    a_port_decode:
        assert property (regWrEn && regAddr == 9'h0f8 |=> portWrEn == 4'b0100
            && portOffset == 7'h08)
        else $error("port window decode wrong");
    a_spare_zero:
        assert property (regRdEn && regAddr == `LCBR_OFS_BASE_CTL |-> ##2 regRdValid
            && regRdData[27:25] == 3'h0)
        else $error("spare bits not zero");
    a_dma_swap:
        assert property ($past(s.baseCtl[`LCBR_BIT_SWAP]) |-> dmaRxOut ==
            byteReverse($past(dmaRxIn)) && dmaTxOut == byteReverse($past(dmaTxIn)))
        else $error("dma byte reverse wrong");
    a_mem_reset:
        assert property (s.baseCtl[`LCBR_BIT_MEM_RST] |=> memCtrlRst)
        else $error("memory reset not held");
    a_time_flags:
        assert property (##1 timeCodeOut == {$past(s.baseCtl[29:28]), $past(timeCount)})
        else $error("time code flags misplaced");
    a_synth_addr:
        assert property (##1 synthAddr == ($past(s.baseCtl[24]) ? 7'h6a : 7'h69))
        else $error("synth address wrong");
    a_synth_gate:
        assert property (!s.baseCtl[`LCBR_BIT_SYN_EN] |=> !synthProbe && !synthRead)
        else $error("synth signals driven while disabled");
    a_eop_wait:
        assert property (s.capState[1] == lcbr_pkg::CAP_WAIT_EOP && !eopSeen[1]
            |=> !captureEn[1])
        else $error("capture began before end of packet");
    a_forward_pin:
        assert property (##3 capDataOut[0] == $past(capDataIn[1], 3))
        else $error("capture data not forwarded");
    a_div_two:
        assert property (linkBitEn[1] && s.baseCtl[9:5] == 5'h01 && !regWrEn
            |=> !linkBitEn[1] ##1 linkBitEn[1])
        else $error("divide by two period wrong");
    a_cap_tx_off:
        assert property (!selfTestLoop |=> txEnable[1:0] == 2'b00)
        else $error("capture port transmit enabled");
    c_capture_run: cover property (captureEn[0] ##1 captureIrq[0]);
    c_err_sticky: cover property (s.errLatch ##1 !s.errLatch);
    c_port_read: cover property (portRdEn[3] ##1 regRdValid);
endmodule

// file: lcbr_cfg.svh
/*
 constants of the link capture base register bank: offsets, fields, resets.
 assumes it is included once per compile unit by its bare name.
*/
// Summary of operation
// - decode base region and four port windows
// - capture port registers cleared by reset
// - capture ports receive only, loopback excepted
// - link-down start: capture once link establishes
// - link-up start: skip until end of packet
// - interrupt host when captured data available
// - base control resets zero, synth enable set
// - bit 31 byte-reverses DMA data only
// - bit 30 holds memory controllers in reset
// - bits 29-28 become time-code bits 7-6
// - bit 24 picks synth address 69/6A
// - bit 23 probes synth address
// - bit 22 one reads, zero writes synth
// - bit 21 resets synth programming logic
// - bit 20 enables synth programming signals
// - four five-bit divisor fields, one per channel
// - divide by field plus one
// - forward capture strobes to opposite port
`ifndef LCBR_CFG_SVH
`define LCBR_CFG_SVH
`define LCBR_OFS_BASE_CTL 9'h000
`define LCBR_OFS_SWITCH 9'h004
`define LCBR_OFS_TIME_CTL 9'h008
`define LCBR_OFS_TIME_RATE 9'h00c
`define LCBR_OFS_SYNTH_FIFO 9'h010
`define LCBR_OFS_SYNTH_STAT 9'h014
`define LCBR_PORT0_BASE 9'h050
`define LCBR_PORT_WIN 9'h050
`define LCBR_BASE_CTL_RST 32'h0010_0000
`define LCBR_BASE_CTL_WMASK 32'hf1ff_ffff
`define LCBR_TIME_CTL_WMASK 32'h0000_7777
`define LCBR_BIT_SWAP 31
`define LCBR_BIT_MEM_RST 30
`define LCBR_BIT_TC_HI 29
`define LCBR_BIT_TC_LO 28
`define LCBR_BIT_ALT_ADDR 24
`define LCBR_BIT_PROBE 23
`define LCBR_BIT_READ 22
`define LCBR_BIT_SYN_RST 21
`define LCBR_BIT_SYN_EN 20
`define LCBR_BIT_ERR 10
`define LCBR_BIT_DONE 9
`define LCBR_SYNTH_ADDR 7'h69
`define LCBR_SYNTH_ADDR_ALT 7'h6a
`endif

// file: lcbr_pkg.sv
/*
 types shared by the link capture base register bank.
 assumes lcbr_cfg.svh holds the numeric constants.
*/
package lcbr_pkg;
    typedef enum logic [1:0] {CAP_IDLE, CAP_WAIT_LINK, CAP_WAIT_EOP, CAP_RUN} lcbr_cap_t;
    typedef struct packed {
        logic [31:0] baseCtl;
        logic [31:0] timeCtl;
        logic [31:0] timeRate;
        logic errLatch;
        logic doneLatch;
        logic portRst;
        logic [7:0] swMeta;
        logic [7:0] swSync;
        logic [3:0] capMeta;
        logic [3:0] capSync;
        logic [3:0] fwdOut;
        logic rdPend;
        logic [8:0] rdAddr;
        logic [31:0] rdData;
        logic rdValid;
        logic [3:0] portWr;
        logic [3:0] portRd;
        logic [6:0] portOff;
        logic [31:0] portWd;
        logic fifoWr;
        logic fifoRd;
        lcbr_cap_t [1:0] capState;
        logic [1:0] capEn;
        logic [1:0] capIrq;
        logic [3:0] txEn;
        logic [31:0] dmaTx;
        logic [31:0] dmaRx;
        logic [7:0] timeCode;
        logic memRst;
        logic [6:0] synAddr;
        logic synProbe;
        logic synRead;
        logic synRst;
        logic synEn;
        logic [19:0] divCnt;
        logic [3:0] bitEn;
    } lcbr_state_t;
endpackage

// file: lcbr_port_model.sv
/*
 port window partner: answers port register reads for all four ports.
 assumes portRdEn and portOffset come registered from the bank on ref_clk.
*/
`timescale 1ns/100ps
module lcbr_port_model (
    input wire logic [3:0] portRdEn,
    input wire logic [6:0] portOffset,
    output logic [127:0] portRdData
);
    // unselected ports show inverted words, never a stale match
    always_comb
    begin
        for (int p = 0; p < 4; p++)
        begin
            portRdData[32*p +: 32] = {16'ha5c0 + 16'(p), 9'h000, portOffset};
            if (portRdEn[p] !== 1'b1)
            begin
                portRdData[32*p +: 32] = ~portRdData[32*p +: 32];
            end
        end
    end
endmodule

// file: lcbr_link_capture_base_regs_tb.sv
/*
 self-checking bench of the base register bank: reads scored from a queue.
 assumes lcbr_cfg.svh offsets and a port model on the port window side.
*/
`timescale 1ns/100ps
`include "lcbr_cfg.svh"
module lcbr_link_capture_base_regs_tb;
    localparam logic [3:0] REV_MINOR = 4'h5; // arbitrary value
    localparam logic [3:0] CFG_TYPE = 4'h9; // arbitrary value
    localparam logic [7:0] REV_MAJOR = 8'h2c; // arbitrary value
    logic ref_clk = 1'b0, rst_n = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0;
    logic calDone = 1'b1, synthReady = 1'b1, synthError = 1'b0, synthDone = 1'b0;
    logic selfTestLoop = 1'b0;
    logic [8:0] regAddr = 9'h000;
    logic [31:0] regWrData = 32'h0, synthFifoRdData = 32'h0, dmaTxIn = 32'h0, dmaRxIn = 32'h0;
    logic [3:0] portIrq = 4'ha;
    logic [7:0] userSwitch = 8'h12;
    logic [2:0] synthRxFlags = 3'h1, synthTxFlags = 3'h1;
    logic [5:0] timeCount = 6'h00;
    logic [1:0] capDataIn = 2'h0, capStrobeIn = 2'h0, captureArm = 2'h0, captureUpStart = 2'h0;
    logic [1:0] linkUp = 2'h0, eopSeen = 2'h0, dataAvail = 2'h0;
    logic [31:0] regRdData, portWrData, timeCtl, timeRate, dmaTxOut, dmaRxOut;
    logic [127:0] portRdData;
    logic [3:0] portWrEn, portRdEn, linkBitEn, txEnable;
    logic [6:0] portOffset, synthAddr;
    logic [7:0] timeCodeOut;
    logic [19:0] linkDivisor;
    logic [1:0] capDataOut, capStrobeOut, capRxData, capRxStrobe, captureEn, captureIrq;
    logic regRdValid, capPortRst, synthFifoWr, synthFifoRd, synthProbe, synthRead;
    logic synthCtrlRst, synthDriveEn, memCtrlRst;
    logic [31:0] seed = 32'd23150;
    logic [31:0] expQ[$];
    int failures = 0;
    int comparisons = 0;

    lcbr_link_capture_base_regs #(.REV_MINOR(REV_MINOR), .CFG_TYPE(CFG_TYPE),
        .REV_MAJOR(REV_MAJOR)) u_dut (.ref_clk, .rst_n, .regWrEn, .regRdEn, .regAddr,
        .regWrData, .regRdData, .regRdValid, .portWrEn, .portRdEn, .portOffset, .portWrData,
        .portRdData, .capPortRst, .portIrq, .calDone, .userSwitch, .synthFifoWr,
        .synthFifoRd, .synthFifoRdData, .synthReady, .synthRxFlags, .synthTxFlags,
        .synthError, .synthDone, .synthAddr, .synthProbe, .synthRead, .synthCtrlRst,
        .synthDriveEn, .memCtrlRst, .timeCtl, .timeRate, .timeCount, .timeCodeOut,
        .dmaTxIn, .dmaTxOut, .dmaRxIn, .dmaRxOut, .linkDivisor, .linkBitEn, .capDataIn,
        .capStrobeIn, .capDataOut, .capStrobeOut, .capRxData, .capRxStrobe, .selfTestLoop,
        .txEnable, .captureArm, .captureUpStart, .linkUp, .eopSeen, .dataAvail,
        .captureEn, .captureIrq);
    lcbr_port_model u_ports (.portRdEn(portRdEn), .portOffset(portOffset),
        .portRdData(portRdData));

    always #5 ref_clk = ~ref_clk;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] bswap(input logic [31:0] d);
        return {d[7:0], d[15:8], d[23:16], d[31:24]};
    endfunction

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
        chk_word(got, exp);
    endtask

    task automatic final_report;
        // reads never answered count as failures
        failures = failures + expQ.size();
        $display("counts: comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
        begin
            $display("Test passed");
        end
        else
        begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        @(negedge ref_clk);
        regWrEn = 1'b1;
        regAddr = a;
        regWrData = d;
        @(negedge ref_clk);
        regWrEn = 1'b0;
    endtask

    // read request notes its expectation for the watcher
    task automatic rd(input logic [8:0] a, input logic [31:0] e);
        @(negedge ref_clk);
        regRdEn = 1'b1;
        regAddr = a;
        expQ.push_back(e);
        @(negedge ref_clk);
        regRdEn = 1'b0;
        repeat (2) @(negedge ref_clk);
    endtask

    task automatic wait_cap(input int p);
        int n;
        n = 0;
        while (captureEn[p] !== 1'b1 && n < 4)
        begin
            @(negedge ref_clk);
            n++;
        end
    endtask

    always @(negedge ref_clk)
    begin
        if (regRdValid === 1'b1)
        begin
            chk_word(regRdData, (expQ.size() > 0) ? expQ.pop_front() : ~regRdData);
        end
    end

    initial
    begin
        #100us;
        failures++;
        final_report;
    end

    initial
    begin
        logic [31:0] v;
        logic [1:0] prevD;
        int n;
        @(negedge ref_clk);
        chk_pin(32'(capPortRst), 32'h1);
        chk_pin(32'(synthDriveEn), 32'h1);
        chk_pin(32'(synthAddr), 32'h69);
        @(negedge ref_clk);
        rst_n = 1'b1;
        portIrq = 4'(xs());
        userSwitch = 8'(xs());
        repeat (2) @(negedge ref_clk);
        chk_pin(32'(capPortRst), 32'h0);
        rd(`LCBR_OFS_BASE_CTL, 32'h0010_0000);
        rd(`LCBR_OFS_SWITCH, {calDone, 3'h0, portIrq, REV_MINOR, CFG_TYPE, REV_MAJOR,
            userSwitch});
        $display("test done: reset values");
        for (int i = 0; i < 6; i++)
        begin
            v = (i == 0) ? 32'hffff_ffff : xs();
            wr(`LCBR_OFS_BASE_CTL, v);
            rd(`LCBR_OFS_BASE_CTL, v & 32'hf1ff_ffff);
            timeCount = 6'(xs());
            dmaTxIn = xs();
            dmaRxIn = xs();
            repeat (2) @(negedge ref_clk);
            chk_pin(32'(memCtrlRst), 32'(v[30]));
            chk_pin(32'(synthAddr), v[24] ? 32'h6a : 32'h69);
            chk_pin(32'(synthProbe), 32'(v[23] & v[20]));
            chk_pin(32'(synthRead), 32'(v[22] & v[20]));
            chk_pin(32'(synthCtrlRst), 32'(v[21]));
            chk_pin(32'(synthDriveEn), 32'(v[20]));
            chk_pin(32'(linkDivisor), 32'(v[19:0]));
            chk_pin(32'(timeCodeOut), 32'({v[29:28], timeCount}));
            chk_pin(dmaTxOut, v[31] ? bswap(dmaTxIn) : dmaTxIn);
            chk_pin(dmaRxOut, v[31] ? bswap(dmaRxIn) : dmaRxIn);
        end
        $display("test done: base control fields");
        for (int p = 0; p < 4; p++)
        begin
            v = xs();
            rd(9'(80 + 80 * p + 4), {16'ha5c0 + 16'(p), 9'h000, 7'h04});
            wr(9'(80 + 80 * p + 8), v);
            chk_pin(32'(portWrEn), 32'(4'h1 << p));
            chk_pin(32'(portOffset), 32'h8);
            chk_pin(portWrData, v);
        end
        wr(9'h018, xs());
        rd(9'h018, 32'h0);
        rd(9'h04c, 32'h0);
        rd(9'h190, 32'h0);
        $display("test done: address decode");
        wr(`LCBR_OFS_TIME_CTL, 32'hffff_ffff);
        rd(`LCBR_OFS_TIME_CTL, 32'h0000_7777);
        chk_pin(timeCtl, 32'h0000_7777);
        v = xs();
        wr(`LCBR_OFS_TIME_RATE, v);
        rd(`LCBR_OFS_TIME_RATE, v);
        chk_pin(timeRate, v);
        wr(`LCBR_OFS_SYNTH_FIFO, v);
        chk_pin(32'(synthFifoWr), 32'h1);
        synthFifoRdData = xs();
        fork
            rd(`LCBR_OFS_SYNTH_FIFO, synthFifoRdData);
            begin
                repeat (2) @(negedge ref_clk);
                chk_pin(32'(synthFifoRd), 32'h1);
            end
        join
        synthError = 1'b1;
        synthDone = 1'b1;
        @(negedge ref_clk);
        synthDone = 1'b0;
        rd(`LCBR_OFS_SYNTH_STAT, 32'h0000_0711);
        // error pulse during the clear: the set wins
        wr(`LCBR_OFS_SYNTH_STAT, 32'h0000_0600);
        synthError = 1'b0;
        rd(`LCBR_OFS_SYNTH_STAT, 32'h0000_0511);
        wr(`LCBR_OFS_SYNTH_STAT, 32'h0000_0400);
        rd(`LCBR_OFS_SYNTH_STAT, 32'h0000_0111);
        $display("test done: time and synth registers");
        wr(`LCBR_OFS_BASE_CTL, 32'h0010_0000 | (32'd31 << 15) | (32'd4 << 10) | (32'd1 << 5));
        repeat (40) @(negedge ref_clk);
        for (int c = 0; c < 4; c++)
        begin
            n = 0;
            while (linkBitEn[c] !== 1'b1 && n < 40)
            begin
                @(negedge ref_clk);
                n++;
            end
            n = 0;
            do
            begin
                @(negedge ref_clk);
                n++;
            end
            while (linkBitEn[c] !== 1'b1 && n < 40);
            chk_pin(32'(n), (c == 3) ? 32'd32 : (c == 2) ? 32'd5 : 32'(c + 1));
        end
        $display("test done: link divisors");
        for (int i = 0; i < 4; i++)
        begin
            v = xs();
            prevD = {capDataIn[0], capDataIn[1]};
            capDataIn = v[1:0];
            capStrobeIn = v[3:2];
            repeat (2) @(negedge ref_clk);
            chk_pin(32'(capRxData), 32'(v[1:0]));
            chk_pin(32'(capRxStrobe), 32'(v[3:2]));
            chk_pin(32'(capDataOut), 32'(prevD));
            @(negedge ref_clk);
            chk_pin(32'(capDataOut), 32'({v[0], v[1]}));
            chk_pin(32'(capStrobeOut), 32'({v[2], v[3]}));
        end
        chk_pin(32'(txEnable), 32'hc);
        selfTestLoop = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk_pin(32'(txEnable), 32'hf);
        $display("test done: forwarding and transmit");
        dataAvail = 2'b11;
        captureArm = 2'b11;
        captureUpStart = 2'b10;
        linkUp = 2'b10;
        repeat (4) @(negedge ref_clk);
        chk_pin(32'(captureEn), 32'h0);
        chk_pin(32'(captureIrq), 32'h0);
        linkUp = 2'b11;
        wait_cap(0);
        chk_pin(32'(captureEn), 32'h1);
        @(negedge ref_clk);
        chk_pin(32'(captureIrq), 32'h1);
        eopSeen = 2'b10;
        @(negedge ref_clk);
        eopSeen = 2'b00;
        wait_cap(1);
        chk_pin(32'(captureEn), 32'h3);
        captureArm = 2'b00;
        repeat (2) @(negedge ref_clk);
        chk_pin(32'(captureEn), 32'h0);
        $display("test done: capture start");
        repeat (4) @(negedge ref_clk);
        final_report;
    end
endmodule
